// *** hw/ufc_fifo_ctrl.sv ***
// UART FIFO control: threshold events, flushes, DMA request pins, transmit and receive FIFOs
// Assumes one 10 MHz clock, a same-clock register port, and a shifter side on the same clock
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module ufc_fifo_ctrl
  import ufc_pkg::*;
#(
  parameter int DEPTH = `UFC_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire ufc_bus_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic tx_wr_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_pop_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic rx_push_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_timeout_i,
  input wire logic rx_rd_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic tx_dma_request_n_o,
  output logic rx_dma_request_n_o,
  output logic irq_o
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    ufc_ctrl_t ctrl;
    logic [PW:0] tx_cnt;
    logic [PW-1:0] tx_rp;
    logic [PW-1:0] tx_wp;
    logic [PW:0] rx_cnt;
    logic [PW-1:0] rx_rp;
    logic [PW-1:0] rx_wp;
    logic tx_empty_ev;
    logic rx_dma_act;
    logic tx_dma_hi;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic [7:0] rdata;
    logic [7:0] rx_out;
    logic [7:0] tx_out;
  } ufc_state_t;

  ufc_state_t s_r, s_nxt;
  logic [7:0] tx_mem [DEPTH];
  logic [7:0] rx_mem [DEPTH];
  logic [PW:0] cap, rx_lvl, tx_lvl;
  logic tx_full, rx_full, tx_push, rx_push, tx_pop, rx_pop;
  logic rx_hit, tx_below, flush_tx, flush_rx, ctrl_wr, st_rd;

  ////////////////////////////////////////////////////////////////////////
  // Threshold decode
  always_comb begin
    unique case (s_r.ctrl.rx_threshold_field)
      2'b00: rx_lvl = (PW+1)'(`UFC_RX_L0);
      2'b01: rx_lvl = (PW+1)'(`UFC_RX_L1);
      2'b10: rx_lvl = (PW+1)'(`UFC_RX_L2);
      2'b11: rx_lvl = (PW+1)'(`UFC_RX_L3);
    endcase
    unique case (s_r.ctrl.tx_thr)
      2'b00: tx_lvl = (PW+1)'(`UFC_TX_L0);
      2'b01: tx_lvl = (PW+1)'(`UFC_TX_L1);
      2'b10: tx_lvl = (PW+1)'(`UFC_TX_L2);
      2'b11: tx_lvl = (PW+1)'(`UFC_TX_L3);
    endcase
  end

  // Disabled FIFOs behave as one-character holding registers
  assign cap = s_r.ctrl.fifo_en ? (PW+1)'(DEPTH) : (PW+1)'(1);
  assign tx_full = s_r.tx_cnt >= cap;
  assign rx_full = s_r.rx_cnt >= cap;
  assign ctrl_wr = bus_i.wr && bus_i.addr == `UFC_OFS_CTRL;
  assign st_rd = bus_i.rd && bus_i.addr == `UFC_OFS_IRQ_ST;
  // Enable change also flushes, so stale data never survives a mode switch
  assign flush_tx = ctrl_wr && (bus_i.wdata[`UFC_BIT_TXFL] && bus_i.wdata[`UFC_BIT_EN]
                    || bus_i.wdata[`UFC_BIT_EN] != s_r.ctrl.fifo_en);
  assign flush_rx = ctrl_wr && (bus_i.wdata[`UFC_BIT_RXFL] && bus_i.wdata[`UFC_BIT_EN]
                    || bus_i.wdata[`UFC_BIT_EN] != s_r.ctrl.fifo_en);
  assign tx_push = tx_wr_i && !tx_full && !flush_tx;
  assign tx_pop = tx_pop_i && s_r.tx_cnt != '0 && !flush_tx;
  // Receiver keeps loading past threshold; excess beyond full is dropped
  assign rx_push = rx_push_i && !rx_full && !flush_rx;
  assign rx_pop = rx_rd_i && s_r.rx_cnt != '0 && !flush_rx;
  assign rx_hit = s_r.rx_cnt >= rx_lvl;
  assign tx_below = s_r.tx_cnt < tx_lvl;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.ctrl.tx_fifo_flush = 1'b0;
    s_nxt.ctrl.rx_fifo_flush = 1'b0;
    if (ctrl_wr) begin
      s_nxt.ctrl.fifo_en = bus_i.wdata[`UFC_BIT_EN];
      if (bus_i.wdata[`UFC_BIT_EN]) begin
        s_nxt.ctrl.rx_threshold_field = bus_i.wdata[7:6];
        s_nxt.ctrl.tx_thr = bus_i.wdata[5:4];
        s_nxt.ctrl.dma_mode = bus_i.wdata[`UFC_BIT_DMA];
        s_nxt.ctrl.tx_fifo_flush = bus_i.wdata[`UFC_BIT_TXFL];
        s_nxt.ctrl.rx_fifo_flush = bus_i.wdata[`UFC_BIT_RXFL];
      end
    end
    if (bus_i.wr && bus_i.addr == `UFC_OFS_IRQ_MASK) begin
      s_nxt.irq_mask = bus_i.wdata[2:0];
    end
    // Transmit and receive counters
    if (flush_tx) begin
      s_nxt.tx_cnt = '0;
      s_nxt.tx_rp = '0;
      s_nxt.tx_wp = '0;
    end else begin
      s_nxt.tx_cnt = s_r.tx_cnt + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
      if (tx_push) s_nxt.tx_wp = s_r.tx_wp + 1'b1;
      if (tx_pop) s_nxt.tx_rp = s_r.tx_rp + 1'b1;
    end
    if (flush_rx) begin
      s_nxt.rx_cnt = '0;
      s_nxt.rx_rp = '0;
      s_nxt.rx_wp = '0;
    end else begin
      s_nxt.rx_cnt = s_r.rx_cnt + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
      if (rx_push) s_nxt.rx_wp = s_r.rx_wp + 1'b1;
      if (rx_pop) s_nxt.rx_rp = s_r.rx_rp + 1'b1;
    end
    if (tx_pop) s_nxt.tx_out = tx_mem[s_r.tx_rp];
    if (rx_pop) s_nxt.rx_out = rx_mem[s_r.rx_rp];
    // Transmit-empty event: set on falling under threshold, set beats clear
    if (st_rd || tx_wr_i) s_nxt.tx_empty_ev = 1'b0;
    if (tx_pop && s_nxt.tx_cnt < tx_lvl && s_r.tx_cnt >= tx_lvl) begin
      s_nxt.tx_empty_ev = 1'b1;
    end
    // Mode 1 receive request holds until FIFO drains
    if (s_nxt.rx_cnt == '0) s_nxt.rx_dma_act = 1'b0;
    else if (rx_hit || rx_timeout_i) s_nxt.rx_dma_act = 1'b1;
    // Mode 1 transmit request: high when full, low below threshold
    if (s_nxt.tx_cnt >= cap) s_nxt.tx_dma_hi = 1'b1;
    else if (s_nxt.tx_cnt < tx_lvl) s_nxt.tx_dma_hi = 1'b0;
    // Sticky events; write one to clear, new event wins
    if (bus_i.wr && bus_i.addr == `UFC_OFS_IRQ_ST) begin
      s_nxt.irq_st = s_r.irq_st & ~bus_i.wdata[2:0];
    end
    if (rx_push && s_r.rx_cnt + 1'b1 == rx_lvl) s_nxt.irq_st[`UFC_IRQ_RX] = 1'b1;
    if (s_nxt.tx_empty_ev && !s_r.tx_empty_ev) s_nxt.irq_st[`UFC_IRQ_TX] = 1'b1;
    if (rx_push_i && rx_full) s_nxt.irq_st[`UFC_IRQ_OVR] = 1'b1;
    // Register read, data one cycle later
    s_nxt.rdata = 8'h00;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        `UFC_OFS_CTRL: s_nxt.rdata = s_r.ctrl;
        `UFC_OFS_STAT: s_nxt.rdata = {3'h0, s_r.tx_empty_ev, rx_hit, s_r.rx_dma_act, tx_full, rx_full};
        `UFC_OFS_IRQ_ST: s_nxt.rdata = {5'h00, s_r.irq_st};
        `UFC_OFS_IRQ_MASK: s_nxt.rdata = {5'h00, s_r.irq_mask};
        `UFC_OFS_TX_LVL: s_nxt.rdata = 8'(s_r.tx_cnt);
        `UFC_OFS_RX_LVL: s_nxt.rdata = 8'(s_r.rx_cnt);
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and storage
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Storage has no reset; counters define what is valid
  always_ff @(posedge clk_i) begin
    if (tx_push) tx_mem[s_r.tx_wp] <= tx_data_i;
    if (rx_push) rx_mem[s_r.rx_wp] <= rx_data_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata_o = s_r.rdata;
  assign tx_data_o = s_r.tx_out;
  assign rx_data_o = s_r.rx_out;
  assign tx_valid_o = s_r.tx_cnt != '0;
  assign rx_valid_o = s_r.rx_cnt != '0;
  assign irq_o = |(s_r.irq_st & s_r.irq_mask);
  // Far DMA moves data only while its request is low
  always_comb begin
    if (s_r.ctrl.fifo_en && s_r.ctrl.dma_mode) begin
      tx_dma_request_n_o = s_r.tx_dma_hi;
      rx_dma_request_n_o = !s_r.rx_dma_act;
    end else begin
      tx_dma_request_n_o = s_r.tx_cnt != '0;
      rx_dma_request_n_o = s_r.rx_cnt == '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_flush_wr;
    ctrl_wr && bus_i.wdata[`UFC_BIT_EN] && bus_i.wdata[`UFC_BIT_TXFL];
  endsequence
  sequence s_tx_cleared;
    s_r.tx_cnt == '0 && !s_r.ctrl.tx_fifo_flush;
  endsequence

  a_tx_flush_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_flush_wr |=> s_r.tx_cnt == '0 ##1 s_tx_cleared) else $error("tx flush failed");
  a_rx_flush_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    flush_rx |=> s_r.rx_cnt == '0 ##1 !s_r.ctrl.rx_fifo_flush) else $error("rx flush failed");
  a_ctrl_guarded: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ctrl_wr && !bus_i.wdata[`UFC_BIT_EN] |=> $stable(s_r.ctrl.dma_mode) && $stable(s_r.ctrl.tx_thr))
    else $error("control bits updated without enable");
  a_rx_thr_event: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rx_push && s_r.rx_cnt + 1'b1 == rx_lvl |=> s_r.irq_st[`UFC_IRQ_RX]) else $error("rx event missed");
  a_rx_mode0_req: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !s_r.ctrl.dma_mode && $rose(rx_valid_o) |-> !rx_dma_request_n_o) else $error("rx request not low");
  a_tx_mode0_req: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(s_r.ctrl.fifo_en && s_r.ctrl.dma_mode) && s_r.tx_cnt == '0 |-> !tx_dma_request_n_o)
    else $error("tx request not low when empty");
  a_rx_mode1_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.fifo_en && s_r.ctrl.dma_mode && rx_hit ##1 s_r.rx_cnt != '0 && $stable(s_r.ctrl)
    |-> !rx_dma_request_n_o) else $error("rx mode 1 request dropped");
  a_tx_full_req: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.fifo_en && s_r.ctrl.dma_mode && tx_full |-> tx_dma_request_n_o) else $error("tx full request");
  a_tx_empty_clr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tx_wr_i && !tx_pop |=> !s_r.tx_empty_ev) else $error("tx empty not cleared");
  a_cnt_bound: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.tx_cnt <= (PW+1)'(DEPTH) && s_r.rx_cnt <= (PW+1)'(DEPTH)) else $error("count overflow");

  ////////////////////////////////////////////////////////////////////////
  // Threshold decode checks against fixed levels
  a_rx_dec_00: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.rx_threshold_field == 2'b00
    |-> rx_lvl == (PW+1)'(8'h08))
    else $error("rx level 0 wrong");

  a_rx_dec_01: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.rx_threshold_field == 2'b01
    |-> rx_lvl == (PW+1)'(8'h10))
    else $error("rx level 1 wrong");

  a_rx_dec_10: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.rx_threshold_field == 2'b10
    |-> rx_lvl == (PW+1)'(8'h18))
    else $error("rx level 2 wrong");

  a_rx_dec_11: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.rx_threshold_field == 2'b11
    |-> rx_lvl == (PW+1)'(8'h1c))
    else $error("rx level 3 wrong");

  a_tx_dec_00: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.tx_thr == 2'b00
    |-> tx_lvl == (PW+1)'(8'h10))
    else $error("tx level 0 wrong");

  a_tx_dec_01: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.tx_thr == 2'b01
    |-> tx_lvl == (PW+1)'(8'h08))
    else $error("tx level 1 wrong");

  a_tx_dec_10: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.tx_thr == 2'b10
    |-> tx_lvl == (PW+1)'(8'h18))
    else $error("tx level 2 wrong");

  a_tx_dec_11: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.tx_thr == 2'b11
    |-> tx_lvl == (PW+1)'(8'h1e))
    else $error("tx level 3 wrong");

  ////////////////////////////////////////////////////////////////////////
  // Control register writes
  a_rx_thr_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ctrl_wr && bus_i.wdata[`UFC_BIT_EN]
    |=> s_r.ctrl.rx_threshold_field == $past(bus_i.wdata[7:6]))
    else $error("rx threshold not written");

  a_tx_thr_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ctrl_wr && bus_i.wdata[`UFC_BIT_EN]
    |=> s_r.ctrl.tx_thr == $past(bus_i.wdata[5:4]))
    else $error("tx threshold not written");

  a_dma_mode_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ctrl_wr && bus_i.wdata[`UFC_BIT_EN]
    |=> s_r.ctrl.dma_mode == $past(bus_i.wdata[`UFC_BIT_DMA]))
    else $error("dma mode not written");

  a_enable_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ctrl_wr
    |=> s_r.ctrl.fifo_en == $past(bus_i.wdata[`UFC_BIT_EN]))
    else $error("enable not written");

  a_rx_thr_guard: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ctrl_wr && !bus_i.wdata[`UFC_BIT_EN]
    |=> $stable(s_r.ctrl.rx_threshold_field))
    else $error("rx threshold written without enable");

  a_tx_flush_self: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.tx_fifo_flush && !ctrl_wr
    |=> !s_r.ctrl.tx_fifo_flush)
    else $error("tx flush bit stuck");

  a_rx_flush_self: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.rx_fifo_flush && !ctrl_wr
    |=> !s_r.ctrl.rx_fifo_flush)
    else $error("rx flush bit stuck");

  a_disabled_depth: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !s_r.ctrl.fifo_en
    |-> s_r.tx_cnt <= (PW+1)'(1) && s_r.rx_cnt <= (PW+1)'(1))
    else $error("holding register overfilled");

  ////////////////////////////////////////////////////////////////////////
  // Fill, events and interrupt bits
  a_rx_fill_on: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rx_push_i && !rx_full && !flush_rx && !rx_rd_i
    |=> s_r.rx_cnt == $past(s_r.rx_cnt) + 1'b1)
    else $error("rx push lost");

  a_rx_overrun: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rx_push_i && rx_full
    |=> s_r.irq_st[`UFC_IRQ_OVR])
    else $error("rx overrun not flagged");

  a_rx_hit_drop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rx_pop && !rx_push && !ctrl_wr && s_r.rx_cnt == rx_lvl
    |=> !rx_hit)
    else $error("rx event not withdrawn");

  a_tx_below_ev: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tx_pop && !tx_push && !ctrl_wr && s_r.tx_cnt == tx_lvl
    |=> s_r.tx_empty_ev && s_r.irq_st[`UFC_IRQ_TX])
    else $error("tx empty event missed");

  a_st_rd_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    st_rd && !tx_pop
    |=> !s_r.tx_empty_ev)
    else $error("status read did not clear");

  a_rdata_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !bus_i.rd
    |=> rdata_o == 8'h00)
    else $error("read data not idle");

  ////////////////////////////////////////////////////////////////////////
  // Request pin levels
  a_tx_mode0_busy: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(s_r.ctrl.fifo_en && s_r.ctrl.dma_mode) && s_r.tx_cnt != '0
    |-> tx_dma_request_n_o)
    else $error("tx request low while loaded");

  a_rx_mode0_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(s_r.ctrl.fifo_en && s_r.ctrl.dma_mode) && s_r.rx_cnt == '0
    |-> rx_dma_request_n_o)
    else $error("rx request low while empty");

  a_rx_mode1_empty: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.fifo_en && s_r.ctrl.dma_mode && s_r.rx_cnt == '0
    |-> rx_dma_request_n_o)
    else $error("rx mode 1 request low while empty");

  a_tx_mode1_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.ctrl.fifo_en && s_r.ctrl.dma_mode && s_r.tx_cnt < tx_lvl && $stable(s_r.ctrl)
    |-> !tx_dma_request_n_o)
    else $error("tx mode 1 request high below threshold");
endmodule

// *** hw/ufc_cfg.svh ***
// Offsets, field positions, reset values and levels for the UART FIFO control block
// Assumes inclusion by the package and the design module only
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH
`define UFC_ADDR_W 4
`define UFC_OFS_CTRL 4'h0
`define UFC_OFS_STAT 4'h1
`define UFC_OFS_IRQ_ST 4'h2
`define UFC_OFS_IRQ_MASK 4'h3
`define UFC_OFS_TX_LVL 4'h4
`define UFC_OFS_RX_LVL 4'h5
`define UFC_CTRL_RST 8'h00
`define UFC_BIT_EN 0
`define UFC_BIT_RXFL 1
`define UFC_BIT_TXFL 2
`define UFC_BIT_DMA 3
`define UFC_DEPTH 32
`define UFC_RX_L0 6'h08
`define UFC_RX_L1 6'h10
`define UFC_RX_L2 6'h18
`define UFC_RX_L3 6'h1c
`define UFC_TX_L0 6'h10
`define UFC_TX_L1 6'h08
`define UFC_TX_L2 6'h18
`define UFC_TX_L3 6'h1e
`define UFC_IRQ_RX 0
`define UFC_IRQ_TX 1
`define UFC_IRQ_OVR 2
`endif

// *** hw/ufc_pkg.sv ***
// Types for the UART FIFO control block
// Assumes ufc_cfg.svh is on the include path
package ufc_pkg;
  `include "ufc_cfg.svh"
  typedef struct packed {
    logic [1:0] rx_threshold_field;
    logic [1:0] tx_thr;
    logic dma_mode;
    logic tx_fifo_flush;
    logic rx_fifo_flush;
    logic fifo_en;
  } ufc_ctrl_t;
  typedef struct packed {
    logic [`UFC_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ufc_bus_t;
endpackage

// *** verif/ufc_dma_model.sv ***
// Behavioural DMA controller facing the request pins
// Assumes the block's clock and reset; go inputs come from the bench
`timescale 1ns/1ps
module ufc_dma_model
  import ufc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic tx_go_i,
  input wire logic rx_go_i,
  input wire logic tx_dma_request_n_i,
  input wire logic rx_dma_request_n_i,
  output logic tx_wr_o,
  output logic [7:0] tx_data_o,
  output logic rx_rd_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Registered sampling lags a cycle, so one refused extra transfer can follow
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_wr_o <= 1'b0;
      rx_rd_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else begin
      tx_wr_o <= tx_go_i && !tx_dma_request_n_i;
      rx_rd_o <= rx_go_i && !rx_dma_request_n_i;
      if (tx_wr_o) begin
        tx_data_o <= tx_data_o + 8'h01;
      end
    end
  end
endmodule

// *** verif/tb_ufc_fifo_ctrl.sv ***
// Self-checking bench for the UART FIFO control block
// Assumes the register map and DMA model of this folder
`timescale 1ns/1ps
module tb_ufc_fifo_ctrl;
  import ufc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  ufc_bus_t bus = '0;
  logic txw = 1'b0, txp = 1'b0, rxp = 1'b0, rxr = 1'b0, rxto = 1'b0, txgo = 1'b0, rxgo = 1'b0;
  logic dtxw, drxr, txv, rxv, txrq, rxrq, irq;
  logic [7:0] rdata, txd, rxd, dmad, v;
  int fail_count = 0;
  int checks_done = 0;
  logic [7:0] rx_lvl [4] = '{8'h08, 8'h10, 8'h18, 8'h1c};
  logic [7:0] tx_lvl [4] = '{8'h10, 8'h08, 8'h18, 8'h1e};
  ufc_fifo_ctrl dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .rdata_o(rdata),
    .tx_wr_i(txw | dtxw), .tx_data_i(dtxw ? dmad : 8'h3c), .tx_pop_i(txp), .tx_valid_o(txv),
    .tx_data_o(txd), .rx_push_i(rxp), .rx_data_i(8'ha5), .rx_timeout_i(rxto), .rx_rd_i(rxr | drxr),
    .rx_data_o(rxd), .rx_valid_o(rxv), .tx_dma_request_n_o(txrq), .rx_dma_request_n_o(rxrq), .irq_o(irq));
  ufc_dma_model dma_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .tx_go_i(txgo), .rx_go_i(rxgo),
    .tx_dma_request_n_i(txrq), .rx_dma_request_n_i(rxrq), .tx_wr_o(dtxw), .tx_data_o(dmad), .rx_rd_o(drxr));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Strobes held high give back-to-back transfers
  task automatic pulse(input int s, input int n);
    repeat (n) begin
      @(posedge clk_i);
      case (s)
        0: txw <= 1'b1;
        1: txp <= 1'b1;
        2: rxp <= 1'b1;
        3: rxr <= 1'b1;
        default: rxto <= 1'b1;
      endcase
    end
    @(posedge clk_i);
    {txw, txp, rxp, rxr, rxto} <= '0;
    #1;
  endtask
  task automatic wait_req(input bit rxside, input logic lvl);
    int i;
    for (i = 0; i < 200 && (rxside ? rxrq : txrq) !== lvl; i++) tick(1);
    if (i == 200) begin
      fail_count++;
      conclude();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(4'h0, v);
    chk(v, 8'h00);
    chk({7'h00, txrq}, 8'h00);
    pulse(0, 1);
    chk({7'h00, txrq}, 8'h01);
    pulse(1, 1);
    chk({7'h00, txrq}, 8'h00);
    chk(txd, 8'h3c);
    chk({7'h00, txv}, 8'h00);
    pulse(2, 2);
    chk({7'h00, rxrq}, 8'h00);
    chk({7'h00, rxv}, 8'h01);
    rd(4'h5, v);
    chk(v, 8'h01);
    pulse(3, 1);
    chk(rxd, 8'ha5);
    chk({7'h00, rxrq}, 8'h01);
    $display("test reset and mode 0 done");
    wr(4'h0, 8'hf8);
    rd(4'h0, v);
    chk(v, 8'h00);
    wr(4'h0, 8'hc9);
    wr(4'h0, 8'h30);
    rd(4'h0, v);
    chk(v, 8'hc8);
    $display("test write guard done");
    for (int k = 0; k < 4; k++) begin
      wr(4'h0, {k[1:0], 6'h03});
      wr(4'h2, 8'h07);
      wr(4'h3, 8'h01);
      pulse(2, int'(rx_lvl[k]) - 1);
      rd(4'h2, v);
      chk(v & 8'h01, 8'h00);
      pulse(2, 1);
      rd(4'h2, v);
      chk(v & 8'h01, 8'h01);
      chk({7'h00, irq}, 8'h01);
      rd(4'h1, v);
      chk(v & 8'h08, 8'h08);
      pulse(3, 1);
      rd(4'h1, v);
      chk(v & 8'h08, 8'h00);
    end
    pulse(2, 6);
    rd(4'h5, v);
    chk(v, 8'h20);
    rd(4'h2, v);
    chk(v & 8'h04, 8'h04);
    $display("test receive thresholds done");
    for (int k = 0; k < 4; k++) begin
      wr(4'h0, {2'b00, k[1:0], 4'hd});
      txgo <= 1'b1;
      wait_req(1'b0, 1'b1);
      txgo <= 1'b0;
      tick(3);
      rd(4'h4, v);
      chk(v, 8'h20);
      wr(4'h2, 8'h07);
      pulse(1, 32 - int'(tx_lvl[k]));
      rd(4'h2, v);
      chk(v & 8'h02, 8'h00);
      chk({7'h00, txrq}, 8'h01);
      pulse(1, 1);
      rd(4'h2, v);
      chk(v & 8'h02, 8'h02);
      chk({7'h00, txrq}, 8'h00);
      rd(4'h1, v);
      chk(v & 8'h10, 8'h00);
    end
    $display("test transmit thresholds done");
    wr(4'h0, 8'h0b);
    pulse(2, 1);
    tick(2);
    chk({7'h00, rxrq}, 8'h01);
    pulse(4, 1);
    tick(1);
    chk({7'h00, rxrq}, 8'h00);
    rxgo <= 1'b1;
    wait_req(1'b1, 1'b1);
    rxgo <= 1'b0;
    tick(3);
    rd(4'h5, v);
    chk(v, 8'h00);
    $display("test receive timeout done");
    pulse(0, 3);
    pulse(2, 2);
    wr(4'h0, 8'h0f);
    rd(4'h4, v);
    chk(v, 8'h00);
    rd(4'h5, v);
    chk(v, 8'h00);
    rd(4'h0, v);
    chk(v & 8'h06, 8'h00);
    $display("test flush done");
    conclude();
  end
endmodule
